// File: sci_dev_model.sv
// Behavioural device model: quadrature outputs, gap control, gated index
`timescale 1ns/1ps
module sci_dev_model (
  // Clock and pins
  input wire logic mclk,
  input wire logic [2:0] selOut,
  input wire logic [2:0] selOe,
  input wire logic testPull,
  input wire logic indexGatePos,
  input wire logic indexGateNeg,
  // Bench motion commands
  input wire logic stepUp,
  input wire logic stepDn,
  input wire logic [3:0] gapCyc,
  // Device outputs
  output logic encA,
  output logic encB,
  output logic encZ
);
  // Output step position within one input cycle, 4 steps per A/B cycle
  logic [5:0] phaseReg = 6'h00;
  logic [7:0] waitReg = 8'h00;
  logic testReg = 1'b0;
  logic swapAB, lead, lag, rawIdx;
  logic [1:0] cntQ;
  logic [4:0] factor;
  logic [4:0] divRatio;
  logic [5:0] lastPhase;
  // a released strap reads as open, a driven one as its level
  function automatic logic [1:0] pinLevel(input logic oe, input logic out);
    return oe ? (out ? sci_pkg::LVL_HI : sci_pkg::LVL_LO) : sci_pkg::LVL_OPEN;
  endfunction
  // strap pair to interpolation factor, high-order select first
  function automatic logic [4:0] pinFactor(input logic [1:0] hi, input logic [1:0] lo);
    case ({hi, lo})
      {sci_pkg::LVL_HI, sci_pkg::LVL_HI}: return 5'h10;
      {sci_pkg::LVL_HI, sci_pkg::LVL_OPEN}: return 5'h0c;
      {sci_pkg::LVL_HI, sci_pkg::LVL_LO}: return 5'h0a;
      {sci_pkg::LVL_OPEN, sci_pkg::LVL_HI}: return 5'h08;
      {sci_pkg::LVL_OPEN, sci_pkg::LVL_OPEN}: return 5'h05;
      {sci_pkg::LVL_OPEN, sci_pkg::LVL_LO}: return 5'h04;
      {sci_pkg::LVL_LO, sci_pkg::LVL_HI}: return 5'h03;
      {sci_pkg::LVL_LO, sci_pkg::LVL_OPEN}: return 5'h02;
      default: return 5'h01;
    endcase
  endfunction
  // core transitions pass undivided at 16, 12, 10; lower factors divide
  function automatic logic [4:0] pinDivider(input logic [4:0] f);
    case (f)
      5'h10, 5'h0c, 5'h0a: return 5'h01;
      5'h08, 5'h05: return 5'h02;
      5'h04, 5'h03: return 5'h04;
      5'h02: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction
  assign factor = pinFactor(pinLevel(selOe[sci_pkg::PIN_RES_HI], selOut[sci_pkg::PIN_RES_HI]),
    pinLevel(selOe[sci_pkg::PIN_RES_LO], selOut[sci_pkg::PIN_RES_LO]));
  assign divRatio = pinDivider(factor);
  assign lastPhase = 6'({factor, 2'h0} - 7'h01);
  // phase pin high swaps the A/B order
  assign swapAB = selOe[sci_pkg::PIN_PHASE] & selOut[sci_pkg::PIN_PHASE];
  // steps wait out the base gap times the divider
  // commands are post-hysteresis steps; no command, no toggle
  always_ff @(posedge mclk) begin
    if (waitReg != 8'h00) waitReg <= waitReg - 8'h01;
    else if (stepUp | stepDn) begin
      if (stepUp) phaseReg <= (phaseReg == lastPhase) ? 6'h00 : phaseReg + 6'h01;
      else phaseReg <= (phaseReg == 6'h00) ? lastPhase : phaseReg - 6'h01;
      waitReg <= 8'(gapCyc) * 8'(divRatio) - 8'h01;
    end
  end
  // current sink latches test operation, mode 3
  always_ff @(posedge mclk) testReg <= testReg | testPull;
  assign cntQ = phaseReg[1:0];
  assign lead = cntQ[1] ^ cntQ[0];
  assign lag = cntQ[1];
  // index window is the first A/B cycle of each input cycle
  assign rawIdx = (phaseReg[5:2] == 4'h0);
  // test mode puts the raw index on A
  assign encA = testReg ? rawIdx : (swapAB ? lead : lag);
  assign encB = swapAB ? lag : lead;
  // gating by A halves the window to half an output cycle
  assign encZ = rawIdx & indexGatePos & ~indexGateNeg & encA;
endmodule // sci_dev_model

// File: sci_host.sv
// Host controller: straps, decodes and counts a sin/cos interpolator's outputs
`timescale 1ns/1ps
module sci_host #(
  parameter int POS_WIDTH = sci_pkg::POS_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // User configuration, static while running
  input wire logic [1:0] cfgResHi,
  input wire logic [1:0] cfgResLo,
  input wire logic [1:0] cfgPhase,
  input wire logic testRequest,
  // Device outputs A, B, Z
  input wire logic encA,
  input wire logic encB,
  input wire logic encZ,
  // Select pins as output drive and enable
  output logic [2:0] selOut,
  output logic [2:0] selOe,
  // Gap-setting pin current sink for test entry
  output logic testPull,
  // Zero comparator enable driven to the device
  input wire logic indexEnable,
  output logic indexGatePos,
  output logic indexGateNeg,
  // Results
  output logic [POS_WIDTH-1:0] position,
  output logic indexSeen,
  output logic dirUp,
  output logic spacingError,
  output logic [4:0] interpFactor
);
  // Reset value comes from a 32-bit constant, so wider counters are refused
  if (POS_WIDTH < 2 || POS_WIDTH > 32) begin : gBadWidth
    $error("POS_WIDTH out of range");
  end

  logic [1:0] aB_reg;
  logic [POS_WIDTH-1:0] pos_reg;
  logic [7:0] gapCnt_reg;
  logic gapErr_reg;
  logic idx_reg;
  logic dir_reg;
  logic [3:0] pull_reg;
  logic [4:0] ipf_reg;
  logic abValid_reg;
  // One count step at the counter's own width
  localparam logic [POS_WIDTH-1:0] POS_ONE = {{(POS_WIDTH - 1){1'b0}}, 1'b1};

  function automatic logic [4:0] decodeFactor(input logic [1:0] hi, input logic [1:0] lo);
    logic [4:0] f;
    f = 5'h01;
    case ({hi, lo})
      {sci_pkg::LVL_HI, sci_pkg::LVL_HI}: f = 5'h10;
      {sci_pkg::LVL_HI, sci_pkg::LVL_OPEN}: f = 5'h0c;
      {sci_pkg::LVL_HI, sci_pkg::LVL_LO}: f = 5'h0a;
      {sci_pkg::LVL_OPEN, sci_pkg::LVL_HI}: f = 5'h08;
      {sci_pkg::LVL_OPEN, sci_pkg::LVL_OPEN}: f = 5'h05;
      {sci_pkg::LVL_OPEN, sci_pkg::LVL_LO}: f = 5'h04;
      {sci_pkg::LVL_LO, sci_pkg::LVL_HI}: f = 5'h03;
      {sci_pkg::LVL_LO, sci_pkg::LVL_OPEN}: f = 5'h02;
      default: f = 5'h01;
    endcase
    return f;
  endfunction

  // tri-level straps: open means no drive
  function automatic logic [1:0] strapDrive(input logic [1:0] lvl);
    return {lvl != sci_pkg::LVL_OPEN, lvl == sci_pkg::LVL_HI};
  endfunction

  // Select pins are released in test operation so test signals come out
  always_comb begin
    logic [1:0] d0;
    logic [1:0] d1;
    logic [1:0] d2;
    d0 = strapDrive(cfgResLo);
    d1 = strapDrive(cfgResHi);
    d2 = strapDrive(cfgPhase);
    selOut = {d2[0], d1[0], d0[0]};
    selOe = testRequest ? 3'h0 : {d2[1], d1[1], d0[1]};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ipf_reg <= 5'h01;
    else ipf_reg <= decodeFactor(cfgResHi, cfgResLo);
  end

  // current sink during power-up window only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pull_reg <= 4'h0;
    else if (pull_reg < 4'(sci_pkg::TEST_PULL_CYC)) pull_reg <= pull_reg + 4'h1;
  end
  assign testPull = testRequest && (pull_reg < 4'(sci_pkg::TEST_PULL_CYC));

  // zero comparator enable as differential pair
  assign indexGatePos = indexEnable;
  assign indexGateNeg = ~indexEnable;

  // Quadrature decode; B leading A counts up with phase lo/open
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) aB_reg <= 2'h0;
    else aB_reg <= {encA, encB};
  end

  // First sample after reset only primes the history; the device may rest
  // at any A/B level, which must not be taken for a step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) abValid_reg <= 1'b0;
    else abValid_reg <= 1'b1;
  end

  logic step;
  logic stepUp;
  always_comb begin
    step = abValid_reg && (aB_reg != {encA, encB}) &&
      ((aB_reg[1] ^ encA) != (aB_reg[0] ^ encB));
    stepUp = ((aB_reg[1] ^ encB) == 1'b1) ^ (cfgPhase == sci_pkg::LVL_HI);
  end

  // direction follows device, which already applied hysteresis
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= sci_pkg::POS_RESET[POS_WIDTH-1:0];
      dir_reg <= 1'b1;
    end else if (step) begin
      pos_reg <= stepUp ? pos_reg + POS_ONE : pos_reg - POS_ONE;
      dir_reg <= stepUp;
    end
  end

  // flag edges closer than the chosen host spacing
  // Reset to the saturated count, so the first edge after reset is never flagged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_reg <= sci_pkg::GAP_CNT_RESET;
      gapErr_reg <= 1'b0;
    end else if (step) begin
      // Restart at one: edges exactly the minimum apart must pass
      gapCnt_reg <= 8'h01;
      if (gapCnt_reg < 8'(sci_pkg::MIN_EDGE_CYC)) gapErr_reg <= 1'b1;
    end else if (gapCnt_reg != 8'hff) begin
      gapCnt_reg <= gapCnt_reg + 8'h01;
    end
  end

  // index accepted only while A is high, phase not in MSB mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) idx_reg <= 1'b0;
    else if (encZ && encA && cfgPhase != sci_pkg::LVL_OPEN) idx_reg <= 1'b1;
  end

  assign position = pos_reg;
  assign dirUp = dir_reg;
  assign spacingError = gapErr_reg;
  assign indexSeen = idx_reg;
  assign interpFactor = ipf_reg;

  // Assertions
  step_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    step |=> pos_reg != $past(pos_reg)) else $error("position did not move");
  pull_window_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pull_reg >= 4'(sci_pkg::TEST_PULL_CYC) |-> !testPull) else $error("late test pull");
  gate_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
    indexGatePos != indexGateNeg) else $error("gate pair equal");
  idx_needs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(idx_reg) |-> $past(encA)) else $error("index without A");
  gap_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    step && gapCnt_reg < 8'(sci_pkg::MIN_EDGE_CYC) |=> gapErr_reg)
    else $error("gap not flagged");
  test_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    testRequest |-> selOe == 3'h0) else $error("select driven in test");
  factor_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($stable(cfgResHi) && $stable(cfgResLo)) ##1 ($stable(cfgResHi) && $stable(cfgResLo))
    |=> $stable(ipf_reg)) else $error("factor moved");
  dir_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
    step |=> dir_reg == $past(stepUp)) else $error("direction lag");

  // Counting: nothing moves without a step, nor on the priming sample
  pos_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !step |=> $stable(pos_reg)) else $error("position moved without step");
  dir_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !step |=> $stable(dir_reg)) else $error("direction moved without step");
  prime_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !abValid_reg |-> !step) else $error("step on priming sample");

  // Sticky flags: kept until reset, never raised without cause
  idx_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    idx_reg |=> idx_reg) else $error("index flag dropped");
  gap_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    gapErr_reg |=> gapErr_reg) else $error("spacing flag dropped");
  gap_clean_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !gapErr_reg && !(step && gapCnt_reg < 8'(sci_pkg::MIN_EDGE_CYC)) |=> !gapErr_reg)
    else $error("spacing flag without close edges");
  // Phase select open puts the MSB on Z, which must not count as index
  msb_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgPhase == sci_pkg::LVL_OPEN && !idx_reg |=> !idx_reg)
    else $error("index taken in MSB mode");

  // Main scenarios
  up_cov: cover property (@(posedge mclk) step && stepUp);
  down_cov: cover property (@(posedge mclk) step && !stepUp);
  index_cov: cover property (@(posedge mclk) $rose(idx_reg));
  gap_cov: cover property (@(posedge mclk) $rose(gapErr_reg));
  test_cov: cover property (@(posedge mclk) $fell(testPull));
endmodule // sci_host

// File: sci_host_tb.sv
// Self-checking bench for the interpolator host controller
`timescale 1ns/1ps
module sci_host_tb;
  logic mclk = 1'b0, rst_n = 1'b0, testRequest = 1'b0, indexEnable = 1'b0;
  logic stepUp = 1'b0, stepDn = 1'b0;
  logic [1:0] cfgResHi = 2'h0, cfgResLo = 2'h0, cfgPhase = 2'h0;
  logic [3:0] gapCyc = 4'h3;
  logic encA, encB, encZ, testPull, indexSeen, dirUp, spacingError, gPos, gNeg;
  logic [2:0] selOut, selOe;
  logic [31:0] position, expPos;
  logic [4:0] interpFactor;
  int errors = 0, checkCount = 0, cycles = 0, seed = 32'h8259;
  always #50 mclk = ~mclk;
  sci_host u_dut (.mclk(mclk), .rst_n(rst_n), .cfgResHi(cfgResHi), .cfgResLo(cfgResLo),
    .cfgPhase(cfgPhase), .testRequest(testRequest), .encA(encA), .encB(encB), .encZ(encZ),
    .selOut(selOut), .selOe(selOe), .testPull(testPull), .indexEnable(indexEnable),
    .indexGatePos(gPos), .indexGateNeg(gNeg), .position(position), .indexSeen(indexSeen),
    .dirUp(dirUp), .spacingError(spacingError), .interpFactor(interpFactor));
  sci_dev_model u_dev (.mclk(mclk), .selOut(selOut), .selOe(selOe), .testPull(testPull),
    .indexGatePos(gPos), .indexGateNeg(gNeg), .stepUp(stepUp), .stepDn(stepDn),
    .gapCyc(gapCyc), .encA(encA), .encB(encB), .encZ(encZ));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Expected factor, indexed hi*3+lo
  function automatic logic [4:0] fac(input logic [1:0] hi, input logic [1:0] lo);
    logic [4:0] t [9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h0C, 5'h10};
    return t[hi * 3 + lo];
  endfunction
  // Inputs change 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    cyc(12);
    rst_n = 1'b1;
    expPos = 32'h0000_0000;
  endtask
  // One step, then a gap of at least two cycles before checking
  task automatic step(input logic up, input int gap);
    stepUp = up;
    stepDn = !up;
    cyc(1);
    stepUp = 1'b0;
    stepDn = 1'b0;
    expPos = up ? expPos + 32'h1 : expPos - 32'h1;
    cyc(gap);
    chk(position, expPos);
    chk({31'h0, dirUp}, {31'h0, up});
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 9; i++) begin
      cfgResHi = 2'(i / 3);
      cfgResLo = 2'(i % 3);
      do_reset();
      cyc(2);
      chk({27'h0, interpFactor}, {27'h0, fac(cfgResHi, cfgResLo)});
    end
    // Random walk in both A/B orders, reversals included
    for (int p = 0; p < 3; p += 2) begin
      cfgPhase = 2'(p);
      do_reset();
      repeat (40) step(1'($random(seed)), 2 + ($random(seed) & 3));
    end
    // Index stays hidden until the zero comparator enables it
    repeat (4) step(1'b1, 2);
    chk({31'h0, indexSeen}, 32'h0);
    indexEnable = 1'b1;
    cyc(1);
    chk({30'h0, gPos, gNeg}, 32'h2);
    // A full input cycle at factor 16 is 64 steps, so one index must pass
    repeat (64) step(1'b1, 2);
    chk({31'h0, indexSeen}, 32'h1);
    // Phase select open: Z carries the MSB, so no index is taken
    cfgPhase = sci_pkg::LVL_OPEN;
    do_reset();
    repeat (64) step(1'b1, 2);
    chk({31'h0, indexSeen}, 32'h0);
    // Device gap set too small: back-to-back edges
    chk({31'h0, spacingError}, 32'h0);
    gapCyc = 4'h1;
    stepUp = 1'b1;
    cyc(2);
    stepUp = 1'b0;
    cyc(3);
    chk({31'h0, spacingError}, 32'h1);
    // Test entry: pins released, current sunk for a limited time
    testRequest = 1'b1;
    do_reset();
    cyc(4);
    chk({29'h0, selOe}, 32'h0);
    chk({31'h0, testPull}, 32'h1);
    cyc(10);
    chk({31'h0, testPull}, 32'h0);
    print_verdict();
  end
endmodule // sci_host_tb

// File: sci_pkg.sv
// Constants shared by the sin/cos interpolator host controller
package sci_pkg;
  // Three-level pin codes
  localparam logic [1:0] LVL_LO = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HI = 2'h2;
  // Two-way pin index of the three select pins
  localparam int PIN_RES_LO = 0;
  localparam int PIN_RES_HI = 1;
  localparam int PIN_PHASE = 2;
  // Counter width and reset value
  localparam int POS_W = 32;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  // Edge spacing limit, ns, and derived cycles at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_EDGE_NS = 200;
  localparam int MIN_EDGE_CYC = (MIN_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Edge gap counter after reset: saturated, as if the last edge were long ago
  localparam logic [7:0] GAP_CNT_RESET = 8'hff;
  // Test entry current pulse time, ns, and cycles
  localparam int TEST_PULL_NS = 1000;
  localparam int TEST_PULL_CYC = (TEST_PULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Test modes
  localparam logic [1:0] TMODE_START = 2'h3;
endpackage
